// File: rtl/siodc_top.v
// system i/o decode, nmi mask, fast reset detect and isa command delay control
// Function
// - nmi equals not mask and any source
// - rtc port bits 6:0 shadowed, read index 96
// - port 92 bit0 rising write resets cpu
// - fast reset detected locally for smi redirect
// - port 92 bits 7:1 ignored
// - primary window 1f0 access starts ide machine
// - primary 1f0-1f7 first cs, 3f6-3f7 second
// - secondary window 170 access starts ide machine
// - secondary 170-177 first cs, 376-377 second
// - legacy peripheral ranges decoded for events
// - two-bit delay code gives 0-3 bus clocks
// - delay fields at bits 1:0, 3:2, 5:4
// - command delay register resets to 05
// - 16-bit memory delay defaults to zero
// - other cycle types default one clock
`timescale 1ns/1ps
`default_nettype none
`include "siodc_map.vh"
module siodc_top #(
  parameter NMI_SRC_W = 4
) (
  input wire mclk,
  input wire rst_b,
  input wire clk_en,
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_index,
  input wire [7:0] cfg_wdata,
  output reg [7:0] cfg_rdata,
  output reg cfg_hit,
  input wire [NMI_SRC_W-1:0] nmi_src,
  output reg cpu_nmi,
  input wire smi_redirect_en,
  output reg cpu_reset_req,
  output reg fast_reset_smi,
  input wire [1:0] ide_window_en,
  input wire [1:0] ide_window_sel,
  output reg ide_chip_select_first_b,
  output reg ide_chip_select_second_b,
  output reg ide_xfer_start,
  output reg [5:0] legacy_event,
  input wire bclk,
  input wire ale_b,
  input wire isa_cycle_go,
  input wire [1:0] isa_cycle_type,
  output reg isa_cmd_active
);
  reg [6:0] rtc_shadow;
  reg nmi_mask;
  reg fast_reset_bit;
  reg [7:0] cmd_delay;
  reg bclk_q;
  reg ale_q;
  reg [1:0] dly_cnt;
  reg dly_run;
  reg [1:0] next_dly;
  wire bclk_s;
  wire ale_s;
  wire nmi_s;
  wire io_acc;
  wire [15:0] ide_cmd_base;
  wire [15:0] ide_ctl_base;
  wire ide_on;
  wire in_cmd;
  wire in_ctl;
  wire bclk_rise;
  wire ale_fall;
  wire [5:0] ev_hit;

  siodc_sync u_sync_bclk (
    .mclk(mclk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .din(bclk),
    .dout(bclk_s)
  );

  siodc_sync u_sync_ale (
    .mclk(mclk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .din(ale_b),
    .dout(ale_s)
  );

  // nmi sources come from pins; synchronise their or as one level
  siodc_sync u_sync_nmi (
    .mclk(mclk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .din(|nmi_src),
    .dout(nmi_s)
  );

  assign io_acc = io_wr | io_rd;

  // window base: 0 primary, 1 secondary, 2 third, 3 fourth
  assign ide_cmd_base = (ide_window_sel == 2'h0) ? `SIODC_IDE_PRI_CMD :
                        (ide_window_sel == 2'h1) ? `SIODC_IDE_SEC_CMD :
                        (ide_window_sel == 2'h2) ? `SIODC_IDE_THD_CMD :
                        `SIODC_IDE_FTH_CMD;
  assign ide_ctl_base = (ide_window_sel == 2'h0) ? `SIODC_IDE_PRI_CTL :
                        (ide_window_sel == 2'h1) ? `SIODC_IDE_SEC_CTL :
                        (ide_window_sel == 2'h2) ? `SIODC_IDE_THD_CTL :
                        `SIODC_IDE_FTH_CTL;
  // primary window uses enable bit 0, all others bit 1
  assign ide_on = (ide_window_sel == 2'h0) ? ide_window_en[0] : ide_window_en[1];
  assign in_cmd = ide_on && (io_addr[15:3] == ide_cmd_base[15:3]);
  assign in_ctl = ide_on && (io_addr[15:1] == ide_ctl_base[15:1]);

  assign ev_hit[`SIODC_EV_KBD] = (io_addr == `SIODC_PORT_KBD_DATA) ||
                                 (io_addr == `SIODC_PORT_KBD_CMD);
  assign ev_hit[`SIODC_EV_COM] = (io_addr[15:3] == 13'h007f) ||
                                 (io_addr[15:3] == 13'h005f) ||
                                 (io_addr[15:3] == 13'h007d) ||
                                 (io_addr[15:3] == 13'h005d);
  assign ev_hit[`SIODC_EV_LPT] = (io_addr[15:3] == 13'h006f) ||
                                 (io_addr[15:3] == 13'h004f) ||
                                 ((io_addr >= 16'h03bc) && (io_addr <= 16'h03be));
  assign ev_hit[`SIODC_EV_FLOPPY] = ((io_addr >= 16'h03f0) && (io_addr <= 16'h03f5)) ||
                                    ((io_addr >= 16'h0370) && (io_addr <= 16'h0375));
  assign ev_hit[`SIODC_EV_VIDEO] = ((io_addr >= 16'h03b0) && (io_addr <= 16'h03bb)) ||
                                   (io_addr[15:5] == 11'h01e);
  assign ev_hit[`SIODC_EV_IDE] = (io_addr[15:3] == 13'h003e) ||
                                 (io_addr[15:3] == 13'h002e) ||
                                 (io_addr[15:1] == 15'h01fb) ||
                                 (io_addr[15:1] == 15'h01bb);

  // port writes and nmi gating
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rtc_shadow <= 7'h00;
      nmi_mask <= 1'b0;
      fast_reset_bit <= 1'b0;
      cpu_nmi <= 1'b0;
      cpu_reset_req <= 1'b0;
      fast_reset_smi <= 1'b0;
    end else if (clk_en) begin
      cpu_reset_req <= 1'b0;
      fast_reset_smi <= 1'b0;
      if (io_wr && (io_addr == `SIODC_PORT_RTC_INDEX)) begin
        rtc_shadow <= io_wdata[6:0];
        nmi_mask <= io_wdata[`SIODC_NMI_MASK_BIT];
      end
      if (io_wr && (io_addr == `SIODC_PORT_FAST_RESET)) begin
        fast_reset_bit <= io_wdata[`SIODC_FAST_RESET_BIT];
        if (!fast_reset_bit && io_wdata[`SIODC_FAST_RESET_BIT]) begin
          if (smi_redirect_en) begin
            fast_reset_smi <= 1'b1;
          end else begin
            cpu_reset_req <= 1'b1;
          end
        end
      end
      cpu_nmi <= ~nmi_mask & nmi_s;
    end
  end

  // chip selects, transfer start and event pulses
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ide_chip_select_first_b <= 1'b1;
      ide_chip_select_second_b <= 1'b1;
      ide_xfer_start <= 1'b0;
      legacy_event <= 6'h00;
    end else if (clk_en) begin
      ide_chip_select_first_b <= ~(io_acc && in_cmd);
      ide_chip_select_second_b <= ~(io_acc && in_ctl);
      ide_xfer_start <= io_acc && ide_on && (io_addr == ide_cmd_base);
      legacy_event <= io_acc ? ev_hit : 6'h00;
    end
  end

  // configuration register access
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_delay <= `SIODC_CMD_DELAY_RESET;
      cfg_rdata <= 8'h00;
      cfg_hit <= 1'b0;
    end else if (clk_en) begin
      if (cfg_wr && (cfg_index == `SIODC_CFG_CMD_DELAY)) begin
        cmd_delay <= cfg_wdata & `SIODC_CMD_DELAY_MASK;
      end
      cfg_hit <= (cfg_rd || cfg_wr) && ((cfg_index == `SIODC_CFG_CMD_DELAY) ||
                 (cfg_index == `SIODC_CFG_RTC_SHADOW));
      if (cfg_rd && (cfg_index == `SIODC_CFG_CMD_DELAY)) begin
        cfg_rdata <= cmd_delay;
      end else if (cfg_rd && (cfg_index == `SIODC_CFG_RTC_SHADOW)) begin
        cfg_rdata <= {1'b0, rtc_shadow};
      end else begin
        cfg_rdata <= 8'h00;
      end
    end
  end

  always @* begin
    case (isa_cycle_type)
      `SIODC_CYC_IO: next_dly = cmd_delay[`SIODC_DLY_IO_LSB +: 2];
      `SIODC_CYC_M8: next_dly = cmd_delay[`SIODC_DLY_M8_LSB +: 2];
      `SIODC_CYC_M16: next_dly = cmd_delay[`SIODC_DLY_M16_LSB +: 2];
      default: next_dly = cmd_delay[`SIODC_DLY_IO_LSB +: 2];
    endcase
  end

  assign bclk_rise = bclk_s & ~bclk_q;
  assign ale_fall = ale_q & ~ale_s;

  // command delay sequencer; delay counted in synchronised bus clocks
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_q <= 1'b0;
      // matches the synchroniser's reset level so no false ale fall follows reset
      ale_q <= 1'b0;
      dly_cnt <= 2'h0;
      dly_run <= 1'b0;
      isa_cmd_active <= 1'b0;
    end else if (clk_en) begin
      bclk_q <= bclk_s;
      ale_q <= ale_s;
      if (!isa_cycle_go) begin
        dly_run <= 1'b0;
        isa_cmd_active <= 1'b0;
      end else if (ale_fall && !isa_cmd_active) begin
        // zero code asserts at ale fall
        if (next_dly == 2'h0) begin
          isa_cmd_active <= 1'b1;
        end else begin
          dly_run <= 1'b1;
          dly_cnt <= next_dly;
        end
      end else if (dly_run && bclk_rise) begin
        if (dly_cnt == 2'h1) begin
          dly_run <= 1'b0;
          isa_cmd_active <= 1'b1;
        end
        dly_cnt <= dly_cnt - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/siodc_map.vh
// address map, field positions and reset values for the system i/o decode block
`ifndef SIODC_MAP_VH
`define SIODC_MAP_VH
`define SIODC_PORT_RTC_INDEX 16'h0070
`define SIODC_PORT_FAST_RESET 16'h0092
`define SIODC_PORT_KBD_DATA 16'h0060
`define SIODC_PORT_KBD_CMD 16'h0064
`define SIODC_CFG_CMD_DELAY 8'h05
`define SIODC_CFG_RTC_SHADOW 8'h96
`define SIODC_CMD_DELAY_RESET 8'h05
`define SIODC_CMD_DELAY_MASK 8'h3f
`define SIODC_NMI_MASK_BIT 7
`define SIODC_FAST_RESET_BIT 0
`define SIODC_DLY_IO_LSB 0
`define SIODC_DLY_M8_LSB 2
`define SIODC_DLY_M16_LSB 4
`define SIODC_CYC_IO 2'h0
`define SIODC_CYC_M8 2'h1
`define SIODC_CYC_M16 2'h2
`define SIODC_IDE_PRI_CMD 16'h01f0
`define SIODC_IDE_PRI_CTL 16'h03f6
`define SIODC_IDE_SEC_CMD 16'h0170
`define SIODC_IDE_SEC_CTL 16'h0376
`define SIODC_IDE_THD_CMD 16'h05f0
`define SIODC_IDE_THD_CTL 16'h07f6
`define SIODC_IDE_FTH_CMD 16'h0570
`define SIODC_IDE_FTH_CTL 16'h0776
`define SIODC_EV_KBD 0
`define SIODC_EV_COM 1
`define SIODC_EV_LPT 2
`define SIODC_EV_FLOPPY 3
`define SIODC_EV_VIDEO 4
`define SIODC_EV_IDE 5
`endif

// File: rtl/siodc_sync.v
// three-stage input synchroniser; output changes when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module siodc_sync (
  input wire mclk,
  input wire rst_b,
  input wire clk_en,
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else if (clk_en) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/siodc_chk.sv
// concurrent checks on the system i/o decode ports
`timescale 1ns/1ps
`default_nettype none
module siodc_chk (
  input wire mclk,
  input wire rst_b,
  input wire clk_en,
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire cfg_rd,
  input wire [7:0] cfg_index,
  input wire cfg_hit,
  input wire cpu_nmi,
  input wire smi_redirect_en,
  input wire cpu_reset_req,
  input wire fast_reset_smi,
  input wire [1:0] ide_window_en,
  input wire [1:0] ide_window_sel,
  input wire ide_chip_select_first_b,
  input wire ide_xfer_start,
  input wire [5:0] legacy_event,
  input wire isa_cycle_go,
  input wire isa_cmd_active
);
  wire acc = clk_en & (io_wr | io_rd);
  wire w92 = clk_en & io_wr & (io_addr == 16'h0092);
  wire w70 = clk_en & io_wr & (io_addr == 16'h0070);
  wire pri = acc & ide_window_en[0] & (ide_window_sel == 2'h0);
  wire cs0 = ide_chip_select_first_b;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  rst_pulse_a: assert property (
    cpu_reset_req |-> $past(w92 & io_wdata[0] & !smi_redirect_en)) else $error("stray reset");
  smi_pulse_a: assert property (
    fast_reset_smi |-> $past(w92 & io_wdata[0] & smi_redirect_en)) else $error("stray smi");
  nmi_mask_a: assert property (
    w70 & io_wdata[7] |-> ##3 !cpu_nmi) else $error("nmi not masked");
  pri_cmd_a: assert property (
    pri & io_addr == 16'h01f0 |=> ide_xfer_start & !cs0) else $error("no ide start");
  pri_top_a: assert property (
    pri & io_addr == 16'h01f7 |=> !ide_xfer_start & !cs0) else $error("bad ide select");
  kbd_event_a: assert property (
    acc & (io_addr == 16'h0060) |=> legacy_event == 6'h01) else $error("no kbd event");
  cfg_hit_a: assert property (
    clk_en & cfg_rd & cfg_index == 8'h05 |=> cfg_hit) else $error("no config hit");
  cmd_drop_a: assert property (
    !isa_cycle_go ##1 !isa_cycle_go |=> !isa_cmd_active) else $error("command outlives cycle");
  cover property (cpu_reset_req);
  cover property (fast_reset_smi);
  cover property (isa_cmd_active);
endmodule
bind siodc_top siodc_chk chk_u (.*);
`default_nettype wire

// File: verification/siodc_isa_model.sv
// isa side model: free bus clock and address latch strobe
`timescale 1ns/1ps
`default_nettype none
module siodc_isa_model (
  input wire logic start,
  output var logic bclk,
  output var logic ale_b,
  output var int rises
);
  initial begin
    bclk = 1'b0;
    ale_b = 1'b1;
    forever #40 bclk = ~bclk;
  end
  always @(posedge bclk) rises <= rises + 1;
  // strobe falls with the clock, so the first rise is half a period away
  always @(posedge start) begin
    @(negedge bclk);
    ale_b <= 1'b0;
    rises <= 0;
    @(negedge bclk);
    ale_b <= 1'b1;
  end
endmodule
`default_nettype wire

// File: verification/test_system_io_decode_control.sv
// self-checking bench for the system i/o decode block
`timescale 1ns/1ps
`default_nettype none
module test_system_io_decode_control;
  logic mclk, rst_b, clk_en, io_wr, io_rd, cfg_wr, cfg_rd, cfg_hit, cpu_nmi, start;
  logic smi_redirect_en, cpu_reset_req, fast_reset_smi, ide_xfer_start, bclk, ale_b;
  logic ide_chip_select_first_b, ide_chip_select_second_b, isa_cycle_go, isa_cmd_active;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, cfg_index, cfg_wdata, cfg_rdata;
  logic [3:0] nmi_src;
  logic [1:0] ide_window_en, ide_window_sel, isa_cycle_type;
  logic [5:0] legacy_event;
  int error_cnt = 0, samples_checked = 0, rises;
  wire [2:0] ide_o = {ide_chip_select_first_b, ide_chip_select_second_b, ide_xfer_start};
  siodc_top dut_u (.*);
  siodc_isa_model isa_u (.start(start), .bclk(bclk), .ale_b(ale_b), .rises(rises));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // m: 0 io read, 1 io write, 2 config read, 3 config write
  task automatic acc(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    {io_addr, cfg_index, io_wdata, cfg_wdata} <= {a, a[7:0], d, d};
    {cfg_wr, cfg_rd, io_wr, io_rd} <= 4'h1 << m;
    wt(1);
    {cfg_wr, cfg_rd, io_wr, io_rd} <= 4'h0;
  endtask
  task automatic t_reg;
    acc(2'd2, 16'h0005, 8'h00);
    chk("dly rst", {cfg_hit, cfg_rdata}, 9'h105);
    acc(2'd3, 16'h0005, 8'hff);
    acc(2'd2, 16'h0005, 8'h00);
    chk("dly rsv", cfg_rdata, 8'h3f);
    acc(2'd2, 16'h0033, 8'h00);
    chk("unmapped", {cfg_hit, cfg_rdata}, 9'h000);
    $display("t_reg done");
  endtask
  task automatic t_nmi;
    nmi_src <= 4'h2;
    acc(2'd1, 16'h0070, 8'h2a);
    acc(2'd2, 16'h0096, 8'h00);
    chk("shadow", cfg_rdata, 8'h2a);
    wt(6);
    chk("nmi", cpu_nmi, 1'b1);
    acc(2'd1, 16'h0070, 8'h80);
    wt(4);
    chk("nmi mask", cpu_nmi, 1'b0);
    acc(2'd1, 16'h0070, 8'h00);
    nmi_src <= 4'h0;
    $display("t_nmi done");
  endtask
  task automatic t_rst;
    acc(2'd1, 16'h0092, 8'h01);
    chk("rst 01", {cpu_reset_req, fast_reset_smi}, 2'b10);
    acc(2'd1, 16'h0092, 8'h03);
    chk("rst 03", cpu_reset_req, 1'b0);
    acc(2'd1, 16'h0092, 8'hfe);
    chk("rst fe", cpu_reset_req, 1'b0);
    acc(2'd1, 16'h0092, 8'hff);
    chk("rst ff", cpu_reset_req, 1'b1);
    acc(2'd1, 16'h0092, 8'h00);
    smi_redirect_en <= 1'b1;
    acc(2'd1, 16'h0092, 8'h01);
    chk("rst smi", {cpu_reset_req, fast_reset_smi}, 2'b01);
    smi_redirect_en <= 1'b0;
    $display("t_rst done");
  endtask
  task automatic t_ide;
    logic [15:0] cb[4] = '{16'h01f0, 16'h0170, 16'h05f0, 16'h0570};
    for (int k = 0; k < 4; k++) begin
      ide_window_sel <= 2'(k);
      ide_window_en <= k ? 2'h2 : 2'h1;
      acc(2'd0, cb[k], 8'h00);
      chk("ide cmd", ide_o, 3'b011);
      acc(2'd1, cb[k] + 16'h0007, 8'h00);
      chk("ide top", ide_o, 3'b010);
      acc(2'd0, cb[k] + 16'h0207, 8'h00);
      chk("ide ctl", ide_o, 3'b100);
    end
    ide_window_en <= 2'h0;
    ide_window_sel <= 2'h0;
    acc(2'd0, 16'h01f0, 8'h00);
    chk("ide off", ide_o, 3'b110);
    $display("t_ide done");
  endtask
  task automatic t_ev;
    logic [15:0] ea[6] = '{16'h0060, 16'h02f8, 16'h0278, 16'h0370, 16'h03b0, 16'h0376};
    for (int k = 0; k < 6; k++) begin
      acc(2'd0, ea[k], 8'h00);
      chk("event", legacy_event, 16'h0001 << k);
    end
    $display("t_ev done");
  endtask
  task automatic t_isa;
    logic [7:0] cd[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h05};
    logic [1:0] ct[6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
    logic [15:0] ex[6] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h0, 16'h1};
    for (int k = 0; k < 6; k++) begin
      acc(2'd3, 16'h0005, cd[k]);
      @(posedge mclk);
      {isa_cycle_type, isa_cycle_go, start} <= {ct[k], 2'b11};
      for (int i = 0; i < 200 && isa_cmd_active !== 1'b1; i++) wt(1);
      chk("cmd dly", rises[15:0], ex[k]);
      @(posedge mclk);
      {isa_cycle_go, start} <= 2'b00;
      wt(3);
      chk("cmd drop", isa_cmd_active, 1'b0);
      // the model ignores a new start until its strobe has gone back high
      wait (ale_b === 1'b1);
      wt(8);
    end
    $display("t_isa done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    {rst_b, clk_en} = 2'b01;
    {io_wr, io_rd, cfg_wr, cfg_rd, smi_redirect_en, isa_cycle_go, start} = '0;
    {io_addr, io_wdata, cfg_index, cfg_wdata, nmi_src} = '0;
    {ide_window_en, ide_window_sel, isa_cycle_type} = '0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_reg;
    t_nmi;
    t_rst;
    t_ide;
    t_ev;
    t_isa;
    test_done;
  end
  // the isa delays dominate: six cycles of under 80 clocks each
  initial begin
    #20000;
    error_cnt++;
    test_done;
  end
endmodule
`default_nettype wire
